// ===== ascp_consts.svh
// register offsets, field positions and timing counts of the auxiliary serial codec port
// assumes inclusion by the port package and the port module only
`ifndef ASCP_CONSTS_SVH
`define ASCP_CONSTS_SVH
`define ASCP_OFS_ADC1_CFG 8'h93
`define ASCP_OFS_ADC1_LO 8'h94
`define ASCP_OFS_ADC1_HI 8'h95
`define ASCP_OFS_PWR_BIAS 8'hc0
`define ASCP_OFS_PASS 8'hc8
`define ASCP_OFS_PROG 8'hf0
`define ASCP_OFS_TRANSMIT_PAYLOAD_REGS 8'hf1
`define ASCP_OFS_RXDATA 8'hf2
`define ASCP_OFS_STATUS 8'hf3
`define ASCP_MODE_LSB 0
`define ASCP_AGC_BIT 3
`define ASCP_SOFT_BIT 4
`define ASCP_BIAS_BIT 6
`define ASCP_ADC_EN_BIT 2
`define ASCP_SAMPLE_BITS 16
`define ASCP_CLK_HZ 40000000
`define ASCP_SAMPLE_HZ 8000
`define ASCP_SAMPLE_CYC (`ASCP_CLK_HZ / `ASCP_SAMPLE_HZ)
`define ASCP_SCLK_HALF_CYC 4
`endif

// ===== ascp_pkg.sv
// types of the auxiliary serial codec port
// assumes the constants header sits in the same folder
`include "ascp_consts.svh"
package ascp_pkg;
  typedef enum logic [3:0] {
    ascp_mode_off = 4'h0,
    ascp_mode_codec = 4'h1,
    ascp_mode_rf = 4'h2,
    ascp_mode_shared = 4'h3
  } ascp_mode_e;
  typedef enum logic [1:0] {
    ascp_idle = 2'b00,
    ascp_shift = 2'b01,
    ascp_done = 2'b10
  } ascp_state_e;
  // host register access as one group
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ascp_req_s;
  // serial pins driven by the port
  typedef struct packed {
    logic sclk;
    logic sdo;
    logic codec_cs_n;
    logic rf_cs_n;
  } ascp_pins_s;
endpackage

// ===== ascp_port.sv
// auxiliary serial port: pcm codec stream, transceiver pass-through writes, agc setup registers
// assumes host register access arrives on core_clk; serial input pin is asynchronous
// How it works
// RQ1: low four bits of program block pick the port configuration; the port decodes bits 2-0 only.
// RQ2: codec mode moves 16-bit samples at 8000 per second.
// RQ3: filtered mic samples shift out on the serial output line.
// RQ4: samples read from serial input are filtered and sent to output path.
// RQ5: host commands the vocoder and moves coded packets itself.
// RQ6: host preloads transmit data; port sends while next block is loaded.
// RQ7: optional soft decision output, four bits per received bit.
// RQ8: port drives select, data and clock only; it never reads the transceiver.
// RQ9: pass-through register writes are forwarded to the transceiver serially.
// RQ10: host programs transceiver synthesiser through pass-through before receive.
// RQ11: agc needs program bit 3 and power bias bit 6 set.
// RQ12: host sets converter one enabled, averaging three, input one.
// RQ13: host writes detector high and low thresholds.
// RQ14: in I/Q mode converter one acts as broadband agc detector.
// RQ15: I/Q mode lets vocoder and transceiver share the port.
// RQ16: each party on the shared port has its own chip select.
// RQ17: transceiver select stays low for the whole forwarded write.
`timescale 1ns/1ps
`include "ascp_consts.svh"
module ascp_port #(
  parameter int SAMPLE_CYC = `ASCP_SAMPLE_CYC,
  parameter int HALF_CYC = `ASCP_SCLK_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ascp_pkg::ascp_req_s host_req,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  input wire logic [15:0] mic_sample,
  output logic [15:0] spk_sample,
  output logic spk_valid,
  input wire logic aux_serial_in_line,
  output logic aux_serial_out_line,
  output logic aux_serial_clock,
  output logic aux_chip_select_n,
  output logic rf_chip_select_n,
  input wire logic [15:0] detector_level,
  output logic agc_attenuate,
  output logic soft_enable
);
  logic [15:0] prog_q, cfg_q, lo_q, hi_q, pwr_q, tx_q, rx_q;
  logic tx_full_q, pass_pend_q, rf_xfer_q, agc_q, rd_q;
  logic [15:0] pass_q, shift_q, rin_q, rdata_q;
  logic [4:0] bit_q;
  logic [15:0] half_cnt_q;
  logic [15:0] samp_cnt_q;
  logic sclk_q, in_s1_q, in_s2_q;
  ascp_pkg::ascp_state_e st_q;
  ascp_pkg::ascp_mode_e mode;
  wire wr = host_req.wr;
  wire [7:0] a = host_req.addr;
  // configuration decode: bit 3 of the program block is the agc enable, so the port use comes from bits 2-0
  assign mode = ascp_pkg::ascp_mode_e'({1'b0, prog_q[`ASCP_MODE_LSB +: 3]}); // [RQ1]
  wire codec_on = (mode == ascp_pkg::ascp_mode_codec) || (mode == ascp_pkg::ascp_mode_shared);
  wire rf_on = (mode == ascp_pkg::ascp_mode_rf) || (mode == ascp_pkg::ascp_mode_shared); // [RQ15]
  wire iq_agc = prog_q[`ASCP_AGC_BIT] && pwr_q[`ASCP_BIAS_BIT] && cfg_q[`ASCP_ADC_EN_BIT] && rf_on;
  wire samp_tick = (samp_cnt_q == 16'(SAMPLE_CYC - 1)); // [RQ2]
  wire half_tick = (half_cnt_q == 16'(HALF_CYC - 1));
  wire idle = (st_q == ascp_pkg::ascp_idle);
  wire start_rf = idle && pass_pend_q && rf_on;
  wire start_codec = idle && !start_rf && samp_tick && codec_on;
  wire wr_pass = wr && (a == `ASCP_OFS_PASS);
  wire wr_tx = wr && (a == `ASCP_OFS_TRANSMIT_PAYLOAD_REGS);
  wire fall = half_tick && sclk_q;
  wire rise = half_tick && !sclk_q;
  wire last_bit = (bit_q == 5'd15);
  // read data select
  wire [15:0] rd_mux =
    (a == `ASCP_OFS_PROG) ? prog_q :
    (a == `ASCP_OFS_ADC1_CFG) ? cfg_q :
    (a == `ASCP_OFS_ADC1_LO) ? lo_q :
    (a == `ASCP_OFS_ADC1_HI) ? hi_q :
    (a == `ASCP_OFS_PWR_BIAS) ? pwr_q :
    (a == `ASCP_OFS_RXDATA) ? rx_q :
    (a == `ASCP_OFS_STATUS) ? {12'h000, agc_q, rf_xfer_q, pass_pend_q, tx_full_q} : 16'h0000;
  // host register writes and pass-through queue
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prog_q <= 16'h0000;
      cfg_q <= 16'h0000;
      lo_q <= 16'h0000;
      hi_q <= 16'h0000;
      pwr_q <= 16'h0000;
      pass_q <= 16'h0000;
      pass_pend_q <= 1'b0;
    end else begin
      if (wr && a == `ASCP_OFS_PROG) prog_q <= host_req.wdata;
      if (wr && a == `ASCP_OFS_ADC1_CFG) cfg_q <= host_req.wdata; // [RQ12]
      if (wr && a == `ASCP_OFS_ADC1_LO) lo_q <= host_req.wdata; // [RQ13]
      if (wr && a == `ASCP_OFS_ADC1_HI) hi_q <= host_req.wdata;
      if (wr && a == `ASCP_OFS_PWR_BIAS) pwr_q <= host_req.wdata; // [RQ11]
      if (wr_pass && !pass_pend_q) begin
        pass_q <= host_req.wdata; // [RQ9]
        pass_pend_q <= 1'b1;
      end else if (start_rf) begin
        pass_pend_q <= 1'b0;
      end
    end
  end
  // transmit holding register: host loads next sample while current one shifts
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_q <= 16'h0000;
      tx_full_q <= 1'b0;
    end else if (wr_tx) begin
      tx_q <= host_req.wdata; // [RQ6]
      tx_full_q <= 1'b1;
    end else if (start_codec) begin
      tx_full_q <= 1'b0;
    end
  end
  // sample rate divider and serial clock divider
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      samp_cnt_q <= 16'h0000;
      half_cnt_q <= 16'h0000;
    end else begin
      samp_cnt_q <= samp_tick ? 16'h0000 : samp_cnt_q + 16'h0001;
      half_cnt_q <= (idle || half_tick) ? 16'h0000 : half_cnt_q + 16'h0001;
    end
  end
  // input pin synchroniser
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in_s1_q <= 1'b0;
      in_s2_q <= 1'b0;
    end else begin
      in_s1_q <= aux_serial_in_line;
      in_s2_q <= in_s1_q;
    end
  end
  // shift engine: 16 bits msb first, data changes on falling clock, sampled on rising
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= ascp_pkg::ascp_idle;
      shift_q <= 16'h0000;
      rin_q <= 16'h0000;
      bit_q <= 5'd0;
      sclk_q <= 1'b0;
      rf_xfer_q <= 1'b0;
    end else begin
      case (st_q)
        ascp_pkg::ascp_idle: begin
          sclk_q <= 1'b0;
          bit_q <= 5'd0;
          if (start_rf) begin
            shift_q <= pass_q; // [RQ8]
            rf_xfer_q <= 1'b1;
            st_q <= ascp_pkg::ascp_shift;
          end else if (start_codec) begin
            shift_q <= tx_full_q ? tx_q : mic_sample; // [RQ3]
            rf_xfer_q <= 1'b0;
            st_q <= ascp_pkg::ascp_shift;
          end
        end
        ascp_pkg::ascp_shift: begin
          if (rise) begin
            sclk_q <= 1'b1;
            rin_q <= {rin_q[14:0], in_s2_q}; // [RQ4]
          end else if (fall) begin
            sclk_q <= 1'b0;
            shift_q <= {shift_q[14:0], 1'b0};
            bit_q <= bit_q + 5'd1;
            if (last_bit) st_q <= ascp_pkg::ascp_done;
          end
        end
        ascp_pkg::ascp_done: begin
          st_q <= ascp_pkg::ascp_idle; // [RQ17]
        end
        default: st_q <= ascp_pkg::ascp_idle;
      endcase
    end
  end
  // received sample filter (two-tap average) and host readback
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_q <= 16'h0000;
      spk_sample <= 16'h0000;
      spk_valid <= 1'b0;
      agc_q <= 1'b0;
      rdata_q <= 16'h0000;
      rd_q <= 1'b0;
    end else begin
      spk_valid <= 1'b0;
      if (st_q == ascp_pkg::ascp_done && !rf_xfer_q) begin
        rx_q <= rin_q;
        spk_sample <= 16'(($signed({rin_q[15], rin_q}) + $signed({rx_q[15], rx_q})) >>> 1); // [RQ4]
        spk_valid <= 1'b1;
      end
      // hysteresis detector on converter one level
      if (!iq_agc) agc_q <= 1'b0;
      else if (detector_level > hi_q) agc_q <= 1'b1; // [RQ14]
      else if (detector_level < lo_q) agc_q <= 1'b0;
      rd_q <= host_req.rd;
      rdata_q <= rd_mux;
    end
  end
  // pin drive: separate selects on the shared clock and data lines
  wire busy = (st_q != ascp_pkg::ascp_idle);
  assign aux_serial_clock = sclk_q;
  assign aux_serial_out_line = shift_q[15];
  assign rf_chip_select_n = !(busy && rf_xfer_q); // [RQ16]
  assign aux_chip_select_n = !(busy && !rf_xfer_q);
  assign host_rdata = rdata_q;
  assign host_rvalid = rd_q;
  assign agc_attenuate = agc_q;
  assign soft_enable = prog_q[`ASCP_SOFT_BIT]; // [RQ7]
  // checks
  rf_select_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ17]
    start_rf |=> !rf_chip_select_n [*2]) else $error("rf select not held");
  cs_exclusive_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ16]
    !(!rf_chip_select_n && !aux_chip_select_n)) else $error("both selects low");
  pass_fwd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ9]
    start_rf |=> shift_q == $past(pass_q)) else $error("pass data not loaded");
  frame_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ2]
    (st_q == ascp_pkg::ascp_done) |-> bit_q == 5'd16) else $error("frame not sixteen bits");
  mode_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ1]
    (mode == ascp_pkg::ascp_mode_off) |-> !start_codec && !start_rf) else $error("off mode active");
  tx_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ6]
    wr_tx |=> tx_full_q) else $error("tx not held");
  codec_out_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ3]
    start_codec && tx_full_q |=> shift_q == $past(tx_q)) else $error("tx sample lost");
  rx_deliver_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ4]
    (st_q == ascp_pkg::ascp_done && !rf_xfer_q) |=> spk_valid) else $error("no rx sample");
  agc_off_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ14]
    !iq_agc |=> !agc_attenuate) else $error("agc active unset");
  agc_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ14]
    iq_agc && (detector_level > hi_q) |=> agc_attenuate) else $error("agc missed strong signal");
  shared_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ15]
    (mode == ascp_pkg::ascp_mode_codec) |-> !start_rf) else $error("rf in codec only");
  soft_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ7]
    $past(rst_n && wr && a == `ASCP_OFS_PROG) |-> soft_enable == $past(host_req.wdata[`ASCP_SOFT_BIT]))
    else $error("soft flag wrong");
  rf_wo_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ8]
    rf_xfer_q && busy |-> !spk_valid) else $error("rf readback used");
endmodule

// ===== ascp_far_model.sv
// far-side model: vocoder on the codec select, transceiver on the transceiver select
// assumes the port's pin bundle and one reply word supplied by the bench
`timescale 1ns/1ps
module ascp_far_model (
  input wire ascp_pkg::ascp_pins_s pins,
  input wire logic [15:0] reply_word,
  output logic aux_serial_in_line,
  output logic [15:0] codec_word,
  output logic [15:0] rf_word
);
  logic [15:0] out_sr;
  initial begin
    out_sr = 16'h0000;
    aux_serial_in_line = 1'b1;
    codec_word = 16'h0000;
    rf_word = 16'h0000;
  end
  // capture on the rising clock, each party only while its own select is low
  always @(posedge pins.sclk) begin
    if (!pins.codec_cs_n) codec_word <= {codec_word[14:0], pins.sdo};
    if (!pins.rf_cs_n) rf_word <= {rf_word[14:0], pins.sdo};
  end
  // vocoder reply, msb first, moved after each falling clock
  always @(negedge pins.codec_cs_n) begin
    out_sr = reply_word;
    aux_serial_in_line = reply_word[15];
  end
  always @(negedge pins.sclk) begin
    if (!pins.codec_cs_n) begin
      out_sr = out_sr << 1;
      aux_serial_in_line = out_sr[15];
    end
  end
  // released line shows the inverse of its last bit, not a held value
  always @(posedge pins.codec_cs_n) aux_serial_in_line = ~aux_serial_in_line;
endmodule

// ===== tb.sv
// self-checking bench of the auxiliary serial codec port
// assumes the port package, the port module and the far-side model are compiled first
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  ascp_pkg::ascp_req_s req = '0;
  logic [15:0] host_rdata, spk_sample, mic = 16'h0000, reply = 16'h8001, cw, rw;
  logic host_rvalid, spk_valid, sin, agc_attenuate, soft_enable;
  logic p_sclk, p_sdo, p_ccs_n, p_rcs_n;
  logic [15:0] det = 16'h0000;
  ascp_pkg::ascp_pins_s pins;
  // pin bundle seen by the far-side model
  assign pins = '{sclk: p_sclk, sdo: p_sdo, codec_cs_n: p_ccs_n, rf_cs_n: p_rcs_n};
  int num_errors = 0, comparisons = 0, rf_low = 0, codec_low = 0, n;
  logic [7:0] t_addr [5] = '{8'h93, 8'h94, 8'h95, 8'hc0, 8'h5a};
  logic [15:0] t_data [5] = '{16'h003c, 16'h0180, 16'h0185, 16'h0040, 16'h1111};
  logic [15:0] t_exp [5] = '{16'h003c, 16'h0180, 16'h0185, 16'h0040, 16'h0000};
  always #12.5 core_clk = ~core_clk;
  ascp_port #(.SAMPLE_CYC(50), .HALF_CYC(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .host_req(req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .mic_sample(mic), .spk_sample(spk_sample),
    .spk_valid(spk_valid), .aux_serial_in_line(sin), .aux_serial_out_line(p_sdo),
    .aux_serial_clock(p_sclk), .aux_chip_select_n(p_ccs_n), .rf_chip_select_n(p_rcs_n),
    .detector_level(det), .agc_attenuate(agc_attenuate), .soft_enable(soft_enable));
  ascp_far_model far (.pins(pins), .reply_word(reply), .aux_serial_in_line(sin), .codec_word(cw), .rf_word(rw));
  // count cycles each select spends low
  always @(posedge core_clk) begin
    if (pins.rf_cs_n === 1'b0) rf_low++;
    if (pins.codec_cs_n === 1'b0) codec_low++;
  end
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (!ok) begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge core_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge core_clk);
    chk(host_rvalid === 1'b1 && host_rdata === e, "register read mismatch");
    req.rd = 1'b0;
  endtask
  // wait for the next received sample pulse, bounded
  task automatic wait_spk;
    n = 0;
    while (spk_valid !== 1'b1 && n < 600) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 600, "no received sample");
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: the whole run needs under 2000 cycles
  initial begin
    #(25 * 20000);
    num_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    chk(pins.rf_cs_n === 1'b1 && pins.codec_cs_n === 1'b1 && pins.sclk === 1'b0, "idle pins");
    // agc setup registers written and read back, unmapped place reads zero
    for (int i = 0; i < 5; i++) wr(t_addr[i], t_data[i]);
    for (int i = 0; i < 5; i++) rd(t_addr[i], t_exp[i]);
    // port off: a pass write must not start any frame
    wr(8'hc8, 16'h0f0f);
    rf_low = 0;
    codec_low = 0;
    repeat (300) @(negedge core_clk);
    chk(rf_low == 0 && codec_low == 0, "frame while port off");
    // transceiver mode: forwarded write framed by its own select only
    wr(8'hf0, 16'h0002);
    repeat (300) @(negedge core_clk);
    wr(8'hc8, 16'ha5c3);
    rf_low = 0;
    codec_low = 0;
    repeat (400) @(negedge core_clk);
    chk(rw === 16'ha5c3, "transceiver word");
    chk(rf_low >= 128 && rf_low <= 140 && codec_low == 0, "transceiver select span");
    // codec mode: first sample from the mic, second from the preloaded transmit register
    mic = 16'h1234;
    wr(8'hf0, 16'h0001);
    rf_low = 0;
    wait_spk();
    chk(cw === 16'h1234, "codec transmit word");
    chk(spk_sample === 16'hc000, "filtered received sample");
    wr(8'hf1, 16'h0ff0);
    wait_spk();
    chk(cw === 16'h0ff0, "preloaded transmit word");
    chk(spk_sample === 16'h8001, "second filtered sample");
    chk(rf_low == 0, "transceiver select during codec frame");
    // soft decision switch
    wr(8'hf0, 16'h0011);
    repeat (2) @(negedge core_clk);
    chk(soft_enable === 1'b1, "soft output enable");
    // shared port with hardware agc: detector hysteresis between the thresholds
    wr(8'hf0, 16'h000b);
    det = 16'h0190;
    repeat (2) @(negedge core_clk);
    chk(agc_attenuate === 1'b1, "agc above high threshold");
    det = 16'h0182;
    repeat (2) @(negedge core_clk);
    chk(agc_attenuate === 1'b1, "agc hysteresis hold");
    det = 16'h0170;
    repeat (2) @(negedge core_clk);
    chk(agc_attenuate === 1'b0, "agc below low threshold");
    wr(8'hc8, 16'h5a0f);
    rf_low = 0;
    codec_low = 0;
    repeat (400) @(negedge core_clk);
    chk(rw === 16'h5a0f && rf_low >= 128 && rf_low <= 140 && codec_low > 0, "shared port traffic");
    // reset in mid run returns pins and registers to idle
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    chk(pins.rf_cs_n === 1'b1 && pins.codec_cs_n === 1'b1 && agc_attenuate === 1'b0, "reset mid run");
    rd(8'hf0, 16'h0000);
    summarize();
  end
endmodule
